// ===== hw/async_serial_port.sv
// Serial port top: wishbone registers, transmitter, receiver
//
// Contract
// - Transmitter and receiver run independently, sharing one baud generator.
// - Line bits are plain NRZ levels.
// - Control-one bit selects eight or nine data bits.
// - Two-bit prescale and three-bit divider give 32 rates.
// - Separate transmit and receive enable bits in control two.
// - Separate receive and transmit interrupt outputs.
// - Control-one polarity bit inverts every transmitted level.
// - Wake by idle line or address mark, chosen by wake bit.
// - Eight event flags, each able to raise an interrupt.
// - Framing and parity errors flagged in status one.
// - Noise flag when sixteenth-bit samples disagree.
// - Receive line sampled at sixteen times the baud rate.
// - Start bit zero before LSB, stop bit one at end.
// - Transmit line idles at one, or at zero when the polarity bit is set.
// - Ninth bit carried in tx and rx ninth-bit fields.
//
// Implementation choice: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module async_serial_port
  import async_serial_port_pkg::*;
#(
  parameter int BASE_DIV = 4
)(
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // Serial lines
  input wire logic rxLine,
  output logic txLine,
  // Interrupts
  output logic irq,
  output logic rxIrq,
  output logic txIrq
);
  import async_serial_port_pkg::*;

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  logic [7:0] ctrl1_q, ctrl2_q, baud_q, irqEn_q;
  logic [3:0] ctrl3Lo_q;
  logic tx9_q, rx9_q;
  logic [7:0] stat1_q, status_q;
  logic [7:0] rxData_q, txBuf_q;
  logic [1:0] stat2_q;
  logic txBuf9_q, ack_q;
  logic [7:0] rdData;
  logic req, wr, rd, lane0, mapped;

  // One answer per request: neither ack nor err may repeat
  assign req = wb_cyc_i && wb_stb_i && !ack_q && !wb_err_o;
  assign lane0 = wb_sel_i[0];
  assign wr = req && wb_we_i && lane0 && mapped;
  assign rd = req && !wb_we_i && mapped;

  // Address decode and read mux
  always_comb
  begin
    mapped = 1'b1;
    rdData = 8'h00;
    case (wb_adr_i)
      OFF_CTRL_ONE: rdData = ctrl1_q;
      OFF_CTRL_TWO: rdData = ctrl2_q;
      OFF_CTRL_THREE: rdData = {rx9_q, tx9_q, 2'b00, ctrl3Lo_q};
      OFF_STAT_ONE: rdData = stat1_q;
      OFF_STAT_TWO: rdData = {6'h00, stat2_q};
      OFF_DATA: rdData = rxData_q;
      OFF_BAUD: rdData = {2'b00, baud_q[5:4], 1'b0, baud_q[2:0]};
      OFF_IRQ_STATUS: rdData = status_q;
      OFF_IRQ_ENABLE: rdData = irqEn_q;
      OFF_IRQ_CLEAR: rdData = 8'h00;
      default: mapped = 1'b0;
    endcase
  end

  // One-cycle ack, err for unmapped addresses
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      ack_q <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= req && mapped;
      wb_err_o <= req && !mapped;
      wb_dat_o <= {24'h00_0000, rdData};
    end
  end
  assign wb_ack_o = ack_q;

  // Control registers
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      ctrl1_q <= RST_CTRL;
      ctrl2_q <= RST_CTRL;
      baud_q <= RST_CTRL;
      irqEn_q <= RST_CTRL;
      ctrl3Lo_q <= RST_CTRL[3:0];
    end
    else if (wr)
    begin
      case (wb_adr_i)
        OFF_CTRL_ONE: ctrl1_q <= wb_dat_i[7:0];
        OFF_CTRL_TWO: ctrl2_q <= wb_dat_i[7:0];
        OFF_CTRL_THREE: ctrl3Lo_q <= wb_dat_i[3:0];
        OFF_BAUD: baud_q <= {2'b00, wb_dat_i[5:4], 1'b0, wb_dat_i[2:0]};
        OFF_IRQ_ENABLE: irqEn_q <= wb_dat_i[7:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Baud generator
  // ----------------------------------------
  baud_tick_if tick();
  assign tick.prescale = baud_q[5:4];
  assign tick.divider = baud_q[2:0];
  baud_tick_gen #(.BASE_DIV(BASE_DIV)) u_baud (
    .core_clk(core_clk),
    .srst(srst),
    .tick(tick)
  );
  logic enable, nine;
  assign enable = ctrl1_q[C1_ENABLE];
  assign nine = ctrl1_q[C1_NINE];

  // ----------------------------------------
  // Transmitter
  // ----------------------------------------
  tx_state_t txState_q;
  logic [11:0] txShift_q;
  logic [3:0] txBits_q, txPhase_q;
  logic txFull_q, txOut_q, txLoad, txBit;
  logic txParity;
  assign txLoad = wr && (wb_adr_i == OFF_DATA);
  assign txParity = ^{txBuf9_q & nine, txBuf_q} ^ ctrl1_q[C1_ODD];

  // Transmit buffer, one character deep
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      txBuf_q <= 8'h00;
      txBuf9_q <= 1'b0;
    end
    else if (txLoad)
    begin
      txBuf_q <= wb_dat_i[7:0];
      txBuf9_q <= tx9_q;
    end
  end
  always_ff @(posedge core_clk)
  begin
    if (srst)
      tx9_q <= 1'b0;
    else if (wr && wb_adr_i == OFF_CTRL_THREE)
      tx9_q <= wb_dat_i[C3_TX9];
  end

  // transmit enable; framing; plain NRZ shifting
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      txState_q <= TX_IDLE;
      txShift_q <= 12'hfff;
      txBits_q <= 4'h0;
      txPhase_q <= 4'h0;
      txFull_q <= 1'b0;
      txOut_q <= 1'b1;
    end
    else
    begin
      if (txLoad)
        txFull_q <= 1'b1;
      if (tick.sampleTick)
      begin
        txPhase_q <= txPhase_q + 4'h1;
        if (txPhase_q == 4'hf)
        begin
          case (txState_q)
            TX_IDLE:
            begin
              txOut_q <= 1'b1;
              if (enable && ctrl2_q[C2_TXEN] && ctrl2_q[C2_BREAK])
              begin
                txState_q <= TX_BREAK;
                txBits_q <= nine ? 4'd10 : 4'd9;
                txOut_q <= 1'b0;
              end
              else if (enable && ctrl2_q[C2_TXEN] && txFull_q && !txLoad)
              begin
                txState_q <= TX_SHIFT;
                txFull_q <= 1'b0;
                txOut_q <= 1'b0;
                txBits_q <= 4'd9 + 4'(nine) + 4'(ctrl1_q[C1_PARON]);
                txShift_q <= ctrl1_q[C1_PARON] ?
                  (nine ? {1'b1, txParity, txBuf9_q, txBuf_q, 1'b1}
                        : {2'b11, txParity, txBuf_q, 1'b1}) :
                  (nine ? {2'b11, txBuf9_q, txBuf_q, 1'b1}
                        : {3'b111, txBuf_q, 1'b1});
              end
            end
            TX_SHIFT:
            begin
              txShift_q <= {1'b1, txShift_q[11:1]};
              txOut_q <= txShift_q[1];
              txBits_q <= txBits_q - 4'h1;
              if (txBits_q == 4'h0)
              begin
                txState_q <= TX_IDLE;
                txOut_q <= 1'b1;
              end
            end
            TX_BREAK:
            begin
              txBits_q <= txBits_q - 4'h1;
              if (txBits_q == 4'h0)
              begin
                txState_q <= TX_IDLE;
                txOut_q <= 1'b1;
              end
            end
            default: txState_q <= TX_IDLE;
          endcase
        end
      end
    end
  end
  assign txBit = txOut_q;
  assign txLine = txBit ^ ctrl1_q[C1_TX_POLARITY_INVERT];

  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  rx_state_t rxState_q;
  logic [3:0] rtCount_q, rxBits_q, idleCnt_q;
  logic [2:0] votes_q;
  logic [10:0] rxShift_q;
  logic rxDone, vote, disagree, rxOn, wakeAsleep_q;
  logic rxNoise_q, frameErr, parErr, rxNine, isBreak;
  assign rxOn = enable && ctrl2_q[C2_RXEN];
  assign vote = (votes_q[0] & votes_q[1]) | (votes_q[1] & votes_q[2]) |
                (votes_q[0] & votes_q[2]);
  assign disagree = (votes_q != 3'b000) && (votes_q != 3'b111);

  // sixteen samples per bit; receive enable
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      rxState_q <= RX_HUNT;
      rtCount_q <= 4'h0;
      rxBits_q <= 4'h0;
      votes_q <= 3'b111;
      rxShift_q <= 11'h000;
      rxNoise_q <= 1'b0;
      idleCnt_q <= 4'h0;
    end
    else if (!rxOn)
      rxState_q <= RX_HUNT;
    else if (tick.sampleTick)
    begin
      rtCount_q <= rtCount_q + 4'h1;
      // Majority of three samples around mid bit
      if (rtCount_q >= SAMPLE_MID - 4'h1 && rtCount_q <= SAMPLE_MID + 4'h1)
        votes_q <= {votes_q[1:0], rxLine};
      case (rxState_q)
        RX_HUNT:
        begin
          rtCount_q <= 4'h0;
          idleCnt_q <= rxLine ? idleCnt_q + 4'(idleCnt_q != 4'hf) : 4'h0;
          if (!rxLine)
            rxState_q <= RX_START;
        end
        RX_START:
          if (rtCount_q == 4'hf)
          begin
            rxNoise_q <= disagree;
            rxBits_q <= 4'd8 + 4'(nine) + 4'(ctrl1_q[C1_PARON]);
            rxState_q <= vote ? RX_HUNT : RX_BITS;
          end
        RX_BITS:
          if (rtCount_q == 4'hf)
          begin
            rxNoise_q <= rxNoise_q | disagree;
            rxShift_q <= {vote, rxShift_q[10:1]};
            rxBits_q <= rxBits_q - 4'h1;
            if (rxBits_q == 4'h0)
              rxState_q <= RX_HUNT;
          end
        default: rxState_q <= RX_HUNT;
      endcase
    end
  end
  assign rxDone = tick.sampleTick && rxState_q == RX_BITS &&
                  rtCount_q == 4'hf && rxBits_q == 4'h0;

  // Align received bits: stop bit is the last vote
  logic [9:0] rxWord;
  always_comb
  begin
    rxWord = rxShift_q[10:1];
    case ({nine, ctrl1_q[C1_PARON]})
      2'b00: rxWord = {2'b00, rxShift_q[10:3]};
      2'b01, 2'b10: rxWord = {1'b0, rxShift_q[10:2]};
      default: rxWord = rxShift_q[10:1];
    endcase
  end
  assign frameErr = !vote;
  assign parErr = ctrl1_q[C1_PARON] &&
    (^(nine ? rxWord[9:0] : {1'b0, rxWord[8:0]}) != ctrl1_q[C1_ODD]);
  assign rxNine = nine ? rxWord[8] : rxWord[7];
  assign isBreak = frameErr && rxWord == 10'h000;

  // wake by address mark or idle line
  always_ff @(posedge core_clk)
  begin
    if (srst)
      wakeAsleep_q <= 1'b0;
    else if (wr && wb_adr_i == OFF_CTRL_TWO)
      wakeAsleep_q <= wb_dat_i[C2_RWU];
    else if (ctrl1_q[C1_WAKE] && rxDone && rxNine)
      wakeAsleep_q <= 1'b0;
    else if (!ctrl1_q[C1_WAKE] && idleCnt_q == 4'hf)
      wakeAsleep_q <= 1'b0;
  end

  // Receive buffer and ninth bit
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      rxData_q <= 8'h00;
      rx9_q <= 1'b0;
      stat2_q <= 2'b00;
    end
    else
    begin
      stat2_q[0] <= rxState_q != RX_HUNT;
      if (rxDone && !wakeAsleep_q)
      begin
        rxData_q <= rxWord[7:0];
        rx9_q <= rxNine;
        stat2_q[1] <= isBreak;
      end
    end
  end

  // ----------------------------------------
  // Status and interrupts
  // ----------------------------------------
  logic [7:0] events, clearMask;
  logic rdData1;
  assign rdData1 = rd && wb_adr_i == OFF_DATA;
  always_comb
  begin
    events = 8'h00;
    events[EV_TXE] = tick.sampleTick && txState_q == TX_IDLE &&
                     txFull_q && txPhase_q == 4'hf;
    events[EV_TXDONE] = tick.sampleTick && txState_q != TX_IDLE &&
                        txBits_q == 4'h0 && txPhase_q == 4'hf;
    events[EV_IDLE] = rxOn && idleCnt_q == 4'he && tick.sampleTick;
    if (rxDone && !wakeAsleep_q)
    begin
      events[EV_RXFULL] = 1'b1;
      events[EV_OVR] = stat1_q[EV_RXFULL] && !rdData1;
      events[EV_NOISE] = rxNoise_q | disagree;
      events[EV_FRAME] = frameErr;
      events[EV_PARITY] = parErr;
    end
  end
  assign clearMask = (wr && wb_adr_i == OFF_IRQ_CLEAR) ? wb_dat_i[7:0]
                                                       : 8'h00;

  // live flags: set wins over clear
  always_ff @(posedge core_clk)
  begin
    if (srst)
      stat1_q <= RST_STAT_ONE;
    else
    begin
      stat1_q[EV_TXE] <= (stat1_q[EV_TXE] && !txLoad) || events[EV_TXE];
      stat1_q[EV_TXDONE] <= (stat1_q[EV_TXDONE] && !txLoad) ||
                            events[EV_TXDONE];
      stat1_q[5:0] <= (stat1_q[5:0] & ~{6{rdData1}}) | events[5:0];
    end
  end

  // Sticky copy with write-one-to-clear, set wins
  always_ff @(posedge core_clk)
  begin
    if (srst)
      status_q <= 8'h00;
    else
      status_q <= (status_q & ~clearMask) | events;
  end

  assign txIrq = |(status_q[7:6] & irqEn_q[7:6]);
  assign rxIrq = |(status_q[5:0] & irqEn_q[5:0]);
  assign irq = txIrq | rxIrq;
endmodule
`default_nettype wire

// ===== hw/async_serial_port_pkg.sv
// Register map, field positions and constants of the serial port
package async_serial_port_pkg;
  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFF_CTRL_ONE = 8'h38;
  localparam logic [7:0] OFF_CTRL_TWO = 8'h39;
  localparam logic [7:0] OFF_CTRL_THREE = 8'h3a;
  localparam logic [7:0] OFF_STAT_ONE = 8'h3b;
  localparam logic [7:0] OFF_STAT_TWO = 8'h3c;
  localparam logic [7:0] OFF_DATA = 8'h3d;
  localparam logic [7:0] OFF_BAUD = 8'h3e;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h40;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h41;
  localparam logic [7:0] OFF_IRQ_CLEAR = 8'h42;
  // ----------------------------------------
  // Control one fields
  // ----------------------------------------
  localparam int C1_ENABLE = 6;
  localparam int C1_TX_POLARITY_INVERT = 5;
  localparam int C1_NINE = 4;
  localparam int C1_WAKE = 3;
  localparam int C1_PARON = 1;
  localparam int C1_ODD = 0;
  // ----------------------------------------
  // Control two fields
  // ----------------------------------------
  localparam int C2_TXEN = 3;
  localparam int C2_RXEN = 2;
  localparam int C2_RWU = 1;
  localparam int C2_BREAK = 0;
  // ----------------------------------------
  // Control three fields
  // ----------------------------------------
  localparam int C3_RX9 = 7;
  localparam int C3_TX9 = 6;
  // ----------------------------------------
  // Status one / event bit positions
  // ----------------------------------------
  localparam int EV_TXE = 7;
  localparam int EV_TXDONE = 6;
  localparam int EV_RXFULL = 5;
  localparam int EV_IDLE = 4;
  localparam int EV_OVR = 3;
  localparam int EV_NOISE = 2;
  localparam int EV_FRAME = 1;
  localparam int EV_PARITY = 0;
  // ----------------------------------------
  // Reset values and timing
  // ----------------------------------------
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_STAT_ONE = 8'hc0;
  localparam int OVERSAMPLE = 16;
  localparam logic [3:0] SAMPLE_MID = 4'h8;
  typedef enum logic [1:0]
  {
    TX_IDLE = 2'b00,
    TX_SHIFT = 2'b01,
    TX_BREAK = 2'b10
  } tx_state_t;
  typedef enum logic [1:0]
  {
    RX_HUNT = 2'b00,
    RX_START = 2'b01,
    RX_BITS = 2'b10
  } rx_state_t;
endpackage

// ===== hw/baud_tick_gen.sv
// Baud generator: 16x sample tick from prescaler and divider
`timescale 1ns/1ps
`default_nettype none
module baud_tick_gen #(
  parameter int BASE_DIV = 4
)(
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Tick bundle
  baud_tick_if.gen tick
);
  // Elaboration check: the divider needs a positive base
  if (BASE_DIV < 1 || BASE_DIV > 255)
  begin : g_bad_base_div
    $error("BASE_DIV out of range");
  end

  // Prescale 1,3,4,13 then divide by 2**divider
  function automatic logic [31:0] period(input logic [1:0] p,
                                         input logic [2:0] d);
    logic [31:0] pre;
    pre = 32'd1;
    case (p)
      2'd0: pre = 32'd1;
      2'd1: pre = 32'd3;
      2'd2: pre = 32'd4;
      2'd3: pre = 32'd13;
      default: pre = 32'd1;
    endcase
    period = (pre * 32'(BASE_DIV)) << d;
  endfunction

  logic [31:0] count_q;

  // Free running divider, reloads on wrap
  always_ff @(posedge core_clk)
  begin
    if (srst)
      count_q <= 32'd0;
    else if (count_q + 32'd1 >= period(tick.prescale, tick.divider))
      count_q <= 32'd0;
    else
      count_q <= count_q + 32'd1;
  end

  assign tick.sampleTick = (count_q == 32'd0);
endmodule
`default_nettype wire

// ===== hw/baud_tick_if.sv
// Tick bundle from the shared baud generator
`timescale 1ns/1ps
`default_nettype none
interface baud_tick_if;
  logic sampleTick;
  logic [1:0] prescale;
  logic [2:0] divider;
  modport gen (output sampleTick, input prescale, divider);
  modport use_side (input sampleTick, output prescale, divider);
endinterface
`default_nettype wire

// ===== verification/async_serial_port_properties.sv
// Bus handshake and interrupt checks of the serial port top
`timescale 1ns/1ps
`default_nettype none
module async_serial_port_properties
  import async_serial_port_pkg::*;
#(
  parameter int BASE_DIV = 4
)(
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  // Serial lines
  input wire logic rxLine,
  input wire logic txLine,
  // Interrupts
  input wire logic irq,
  input wire logic rxIrq,
  input wire logic txIrq
);
  import async_serial_port_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  // Address decode: two blocks of byte registers
  logic mapped;
  assign mapped = (wb_adr_i >= OFF_CTRL_ONE && wb_adr_i <= OFF_BAUD) ||
    (wb_adr_i >= OFF_IRQ_STATUS && wb_adr_i <= OFF_IRQ_CLEAR);
  // Request taken, then a one-cycle answer
  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  endsequence
  sequence answer_s;
    (wb_ack_o ^ wb_err_o) ##1 (!wb_ack_o && !wb_err_o);
  endsequence
  AST_REQ_ANSWER: assert property (req_s |=> answer_s)
    else $error("bus request not answered by a single pulse");
  AST_MAPPED_ACK: assert property (req_s ##0 mapped |=> wb_ack_o)
    else $error("mapped access without ack");
  AST_UNMAPPED_ERR: assert property (req_s ##0 !mapped |=> wb_err_o)
    else $error("unmapped access without err");
  AST_NO_SPURIOUS: assert property
    ((wb_ack_o || wb_err_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("answer without request");
  AST_DAT_UPPER: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read lanes not zero");
  AST_BAUD_RSVD: assert property
    (wb_ack_o && !wb_we_i && wb_adr_i == OFF_BAUD |->
     wb_dat_o[7:6] == 2'h0 && !wb_dat_o[3])
    else $error("reserved baud bits read nonzero");
  AST_STAT2_RSVD: assert property
    (wb_ack_o && !wb_we_i && wb_adr_i == OFF_STAT_TWO |->
     wb_dat_o[7:2] == 6'h00)
    else $error("reserved status two bits read nonzero");
  AST_IRQ_SPLIT: assert property (irq == (rxIrq || txIrq))
    else $error("combined interrupt disagrees with split ones");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  AST_ERR_PULSE: assert property (wb_err_o |=> !wb_err_o)
    else $error("err held longer than one cycle");
endmodule
bind async_serial_port async_serial_port_properties #(.BASE_DIV(BASE_DIV))
  i_async_serial_port_properties (.core_clk(core_clk), .srst(srst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
  .rxLine(rxLine), .txLine(txLine), .irq(irq), .rxIrq(rxIrq),
  .txIrq(txIrq));
`default_nettype wire

// ===== verification/remote_serial_dev.sv
// Far-end serial device: sends frames, decodes the transmit line
`timescale 1ns/1ps
`default_nettype none
module remote_serial_dev (
  // Clock
  input wire logic core_clk,
  // Serial lines
  input wire logic txLine,
  output var logic rxLine,
  // Line setup
  input wire logic inv,
  input wire logic listen,
  input wire logic [3:0] nBits,
  input wire logic [15:0] bitCyc
);
  logic [8:0] gotQ[$];
  logic [8:0] word;
  logic badStop = 1'b0;
  int k;
  initial rxLine = 1'b1;
  // Start 0, data LSB first, chosen stop level, then mark idle
  task automatic send(input logic [8:0] v, input logic stopBit);
    int i;
    @(posedge core_clk);
    for (i = 0; i < nBits + 2; i++)
    begin
      rxLine <= (i == 0) ? 1'b0 : (i == nBits + 1) ? stopBit : v[i - 1];
      repeat (bitCyc) @(posedge core_clk);
    end
    rxLine <= 1'b1;
    repeat (2 * bitCyc) @(posedge core_clk);
  endtask
  // Mid-bit sampling after a start level; polarity undone first
  always
  begin
    @(posedge core_clk iff (listen && (txLine ^ inv) == 1'b0));
    word = 9'h000;
    repeat (bitCyc / 2) @(posedge core_clk);
    for (k = 0; k < nBits; k++)
    begin
      repeat (bitCyc) @(posedge core_clk);
      word[k] = txLine ^ inv;
    end
    repeat (bitCyc) @(posedge core_clk);
    if ((txLine ^ inv) !== 1'b1)
      badStop = 1'b1;
    gotQ.push_back(word);
  end
endmodule
`default_nettype wire

// ===== verification/tb.sv
// Self-checking bench of the serial port
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) \
  begin n_tests++; if ((got) !== (exp)) begin mismatches++; \
  $display("ERROR %s expected %0h seen %0h", nm, exp, got); end end
module tb
  import async_serial_port_pkg::*;
;
  import async_serial_port_pkg::*;
  localparam int BASE_DIV = 1;
  localparam int PRE [4] = '{1, 3, 4, 13};
  localparam logic [7:0] RADR [5] = '{OFF_CTRL_ONE, OFF_CTRL_TWO,
    OFF_STAT_ONE, OFF_STAT_TWO, OFF_BAUD};
  localparam logic [7:0] RVAL [5] = '{8'h00, 8'h00, 8'hc0, 8'h00, 8'h00};
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic wbWe = 1'b0;
  logic [7:0] wbAdr = 8'h00;
  logic [31:0] wbDatI = 32'h0;
  logic [31:0] wbDatO;
  logic wbAck, wbErr, rxLine, txLine, irq, rxIrq, txIrq, lastErr;
  logic inv = 1'b0;
  logic listen = 1'b0;
  logic [3:0] nBits = 4'h8;
  logic [15:0] bitCyc = 16'h0010;
  logic [7:0] q;
  logic [8:0] d, e, g;
  logic [2:0] dv;
  int mismatches = 0;
  int n_tests = 0;
  int i, t;
  always #2 core_clk = ~core_clk;
  async_serial_port #(.BASE_DIV(BASE_DIV)) i_async_serial_port (
    .core_clk(core_clk), .srst(srst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hf), .wb_dat_i(wbDatI),
    .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .wb_err_o(wbErr),
    .rxLine(rxLine), .txLine(txLine), .irq(irq), .rxIrq(rxIrq),
    .txIrq(txIrq));
  remote_serial_dev i_remote_serial_dev (.core_clk(core_clk),
    .txLine(txLine), .rxLine(rxLine), .inv(inv), .listen(listen),
    .nBits(nBits), .bitCyc(bitCyc));
  // Classic single cycle; held until ack or err is sampled
  task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbDatI <= {24'h0, v};
    t = 0;
    do
    begin
      @(posedge core_clk);
      t++;
    end while (wbAck !== 1'b1 && wbErr !== 1'b1 && t < 20);
    q = wbDatO[7:0];
    lastErr = wbErr;
    if (t >= 20)
      mismatches++;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask
  // Bounded waits on the partner queue and the receive interrupt
  task automatic wait_tx();
    for (t = 0; i_remote_serial_dev.gotQ.size() == 0 && t < 6000; t++)
      @(posedge core_clk);
    if (t >= 6000)
      mismatches++;
  endtask
  task automatic wait_rx();
    for (t = 0; rxIrq !== 1'b1 && t < 400; t++)
      @(posedge core_clk);
    if (t >= 400)
      mismatches++;
  endtask
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Watchdog: the whole sequence needs at most about 11k cycles
  initial
  begin
    repeat (80000) @(posedge core_clk);
    mismatches++;
    report_and_stop();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    void'($urandom(23));
    repeat (20) @(posedge core_clk);
    srst <= 1'b0;
    for (i = 0; i < 5; i++)
    begin
      wb(1'b0, RADR[i], 8'h00);
      `CHK("reset value", RVAL[i], q)
    end
    wb(1'b1, OFF_BAUD, 8'hff);
    wb(1'b0, OFF_BAUD, 8'h00);
    `CHK("baud fields", 8'h37, q)
    wb(1'b1, OFF_STAT_ONE, 8'h00);
    wb(1'b0, OFF_STAT_ONE, 8'h00);
    `CHK("status one read-only", RST_STAT_ONE, q)
    wb(1'b0, 8'h50, 8'h00);
    `CHK("unmapped err", 1'b1, lastErr)
    wb(1'b1, OFF_IRQ_ENABLE, 8'hff);
    wb(1'b1, OFF_CTRL_TWO, 8'h0c);
    $display("Test registers finished");
    // Transmit at every prescale, both polarities and lengths
    for (i = 0; i < 4; i++)
    begin
      listen <= 1'b0;
      dv = 3'($urandom_range(1, 0));
      d = 9'($urandom_range(511, 0));
      d[8] = d[8] & i[0];
      wb(1'b1, OFF_BAUD, {2'h0, i[1:0], 1'b0, dv});
      wb(1'b1, OFF_CTRL_ONE, {2'h1, i[1], i[0], 4'h0});
      wb(1'b1, OFF_CTRL_THREE, {1'b0, d[8], 6'h00});
      @(posedge core_clk);
      inv <= i[1];
      nBits <= i[0] ? 4'h9 : 4'h8;
      bitCyc <= 16'((16 * BASE_DIV * PRE[i]) << dv);
      listen <= 1'b1;
      wb(1'b1, OFF_DATA, d[7:0]);
      wait_tx();
      e = d;
      g = i_remote_serial_dev.gotQ.pop_front();
      `CHK("tx frame", e, g)
      `CHK("tx stop", 1'b0, i_remote_serial_dev.badStop)
      repeat (bitCyc) @(posedge core_clk);
      `CHK("tx idle", ~i[1], txLine)
      $display("Test transmit %0d finished", i);
    end
    wb(1'b0, OFF_IRQ_STATUS, 8'h00);
    `CHK("tx done event", 1'b1, q[EV_TXDONE])
    `CHK("tx irq", 1'b1, txIrq)
    `CHK("irq", 1'b1, irq)
    // Receive good, nine-bit, framing and parity faults
    listen <= 1'b0;
    wb(1'b1, OFF_BAUD, 8'h00);
    bitCyc <= 16'h0010;
    for (i = 0; i < 4; i++)
    begin
      wb(1'b1, OFF_CTRL_ONE, {2'h1, 1'b0, i == 1, 2'h0, i == 3, 1'b0});
      wb(1'b1, OFF_IRQ_CLEAR, 8'hff);
      d = 9'($urandom_range(511, 1));
      d[8] = (i == 3) ? ~^d[7:0] : d[8] & (i == 1);
      nBits <= (i == 1 || i == 3) ? 4'h9 : 4'h8;
      i_remote_serial_dev.send(d, i != 2);
      wait_rx();
      `CHK("rx irq", 1'b1, rxIrq)
      wb(1'b0, OFF_STAT_ONE, 8'h00);
      `CHK("rx status", {5'h04, 1'b0, i == 2, i == 3}, q & 8'h23)
      wb(1'b0, OFF_DATA, 8'h00);
      `CHK("rx data", d[7:0], q)
      wb(1'b0, OFF_CTRL_THREE, 8'h00);
      if (i == 1)
        `CHK("rx ninth", d[8], q[C3_RX9])
      $display("Test receive %0d finished", i);
    end
    // Second character before the first is read
    wb(1'b1, OFF_CTRL_ONE, 8'h40);
    nBits <= 4'h8;
    i_remote_serial_dev.send(9'h0a5, 1'b1);
    i_remote_serial_dev.send(9'h05a, 1'b1);
    wb(1'b0, OFF_STAT_ONE, 8'h00);
    `CHK("overrun", 1'b1, q[EV_OVR])
    wb(1'b0, OFF_DATA, 8'h00);
    $display("Test overrun finished");
    // Address-mark wake: plain characters ignored while asleep
    wb(1'b1, OFF_CTRL_ONE, 8'h58);
    wb(1'b1, OFF_CTRL_TWO, 8'h0e);
    nBits <= 4'h9;
    i_remote_serial_dev.send(9'h033, 1'b1);
    wb(1'b0, OFF_STAT_ONE, 8'h00);
    `CHK("asleep rx full", 1'b0, q[EV_RXFULL])
    i_remote_serial_dev.send(9'h1c3, 1'b1);
    i_remote_serial_dev.send(9'h03c, 1'b1);
    wb(1'b0, OFF_DATA, 8'h00);
    `CHK("woken rx data", 8'h3c, q)
    $display("Test wake finished");
    report_and_stop();
  end
endmodule
`default_nettype wire
